// File: hdl/mdnsu_unit.sv
// multiply, divide, normalize and shift accelerator with its registers
`timescale 1ns/1ps
`include "mdnsu_defines.svh"

module mdnsu_unit (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // special function register access
    input wire mdnsu_pkg::mdnsu_access_type sfrAccess,
    output logic [7:0] sfrReadData,
    // status
    output logic [7:0] controlStatus,
    output logic busy
);
    import mdnsu_pkg::*;

    mdnsu_top_type st_q;
    mdnsu_top_type st_d;
    logic divDone;
    logic [31:0] divQuot;
    logic [15:0] divRem;
    logic shfDone;
    logic [31:0] shfResult;
    logic [4:0] shfCount;
    logic [31:0] product;
    logic [15:0] newDivisor;
    logic errSet;
    logic errClr;

    // byte index expected at each step of the result reads
    function automatic logic [2:0] readSel(mdnsu_op_type op,
                                           logic [2:0] pos);
        if (op == OP_DIV16 && pos[1])
            readSel = {2'b10, pos[0]};
        else
            readSel = pos;
    endfunction

    function automatic logic readLast(mdnsu_op_type op, logic [2:0] pos);
        if (op == OP_DIV32)
            readLast = (pos == 3'h5);
        else
            readLast = (pos == 3'h3);
    endfunction

    function automatic logic [7:0] ctrlByte(mdnsu_ctrl_type c);
        ctrlByte = {c.errFlag, c.ovFlag, c.dirRight, c.shiftCount};
    endfunction

    // the access addresses the control/status register
    function automatic logic isCtrl(logic [2:0] sel);
        isCtrl = (sel == `MDNSU_SEL_CTRL);
    endfunction

    // the access addresses one of the six operand bytes
    function automatic logic isByte(logic [2:0] sel);
        isByte = (sel <= `MDNSU_SEL_BYTE_LAST);
    endfunction

    // a zero count field asks for normalization, not a shift
    function automatic logic isNorm(logic [4:0] count);
        isNorm = (count == `MDNSU_SC_NORM);
    endfunction

    // an abandoned division keeps running; its done pulse is ignored
    // unless a division is still awaited
    mdnsu_divider divider (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(st_q.divStart),
        .dividend(st_q.op == OP_DIV16 ?
                  {16'h0000, st_q.bytes[1], st_q.bytes[0]} :
                  st_q.bytes[3:0]),
        .divisor(st_q.bytes[5:4]),
        .done(divDone),
        .quotient(divQuot),
        .remainder(divRem)
    );

    // normalization and shifting share one iterative engine
    mdnsu_shifter shifter (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .start(st_q.shfStart),
        .norm(isNorm(st_q.ctrl.shiftCount)),
        .right(st_q.ctrl.dirRight),
        .count(st_q.ctrl.shiftCount),
        .operand(st_q.bytes[3:0]),
        .done(shfDone),
        .result(shfResult),
        .shifts(shfCount)
    );

    // formed in the cycle of the last write so it lands with that write
    assign product = {16'h0000, st_q.bytes[1], st_q.bytes[0]} *
                     {16'h0000, sfrAccess.wrData, st_q.bytes[4]};
    assign newDivisor = {sfrAccess.wrData, st_q.bytes[4]};

    always_comb
    begin
        st_d = st_q;
        st_d.divStart = 1'b0;
        st_d.shfStart = 1'b0;
        errSet = 1'b0;
        errClr = 1'b0;

        // read data, answered one clock after the strobe
        if (sfrAccess.rdEn)
        begin
            if (isCtrl(sfrAccess.sel))
                st_d.rdData = ctrlByte(st_q.ctrl);
            else if (isByte(sfrAccess.sel))
                st_d.rdData = st_q.bytes[sfrAccess.sel];
            else
                st_d.rdData = `MDNSU_UNMAPPED_READ;
        end

        if (sfrAccess.rdEn && isCtrl(sfrAccess.sel))
            errClr = 1'b1;

        if (sfrAccess.rdEn && st_q.state == ST_READ &&
            sfrAccess.sel == readSel(st_q.op, st_q.readPos))
        begin
            if (readLast(st_q.op, st_q.readPos))
            begin
                st_d.state = ST_IDLE;
                errClr = 1'b1;
            end
            else
                st_d.readPos = st_q.readPos + 3'h1;
        end

        // operand byte writes and the write sequence tracker
        if (sfrAccess.wrEn && isByte(sfrAccess.sel))
        begin
            st_d.bytes[sfrAccess.sel] = sfrAccess.wrData;
            if (sfrAccess.sel == 3'h0)
            begin
                if (st_q.state != ST_IDLE)
                    errSet = 1'b1;
                st_d.state = ST_W0;
            end
            else
            begin
                unique case (st_q.state)
                    ST_IDLE:
                        st_d.state = ST_IDLE;
                    ST_W0:
                        if (sfrAccess.sel == 3'h1)
                            st_d.state = ST_W01;
                        else if (sfrAccess.sel == 3'h4)
                            st_d.state = ST_W04;
                        else
                            errSet = 1'b1;
                    ST_W01:
                        if (sfrAccess.sel == 3'h2)
                            st_d.state = ST_W012;
                        else if (sfrAccess.sel == 3'h4)
                            st_d.state = ST_W014;
                        else
                            errSet = 1'b1;
                    ST_W012:
                        if (sfrAccess.sel == 3'h3)
                            st_d.state = ST_W0123;
                        else
                            errSet = 1'b1;
                    ST_W0123:
                        if (sfrAccess.sel == 3'h4)
                            st_d.state = ST_W01234;
                        else
                            errSet = 1'b1;
                    ST_W04:
                        if (sfrAccess.sel == 3'h1)
                            st_d.state = ST_W041;
                        else
                            errSet = 1'b1;
                    ST_W01234, ST_W014:
                        if (sfrAccess.sel == 3'h5)
                        begin
                            st_d.op = (st_q.state == ST_W014) ?
                                      OP_DIV16 : OP_DIV32;
                            st_d.divStart = 1'b1;
                            st_d.state = ST_DIV;
                            st_d.ctrl.ovFlag = (newDivisor == 16'h0000);
                        end
                        else
                            errSet = 1'b1;
                    ST_W041:
                        if (sfrAccess.sel == 3'h5)
                        begin
                            st_d.op = OP_MUL;
                            st_d.bytes[3:0] = product;
                            st_d.readPos = 3'h0;
                            st_d.state = ST_READ;
                            st_d.ctrl.ovFlag = (product > `MDNSU_MUL_LIMIT);
                        end
                        else
                            errSet = 1'b1;
                    ST_DIV, ST_SHF, ST_READ:
                        errSet = 1'b1;
                    default:
                        errSet = 1'b1;
                endcase
                // an out-of-order write abandons the operation
                if (errSet)
                    st_d.state = ST_IDLE;
            end
        end

        // control writes: flag bits are owned by hardware
        if (sfrAccess.wrEn && isCtrl(sfrAccess.sel))
        begin
            st_d.ctrl.dirRight = sfrAccess.wrData[`MDNSU_DIR_BIT];
            st_d.ctrl.shiftCount =
                sfrAccess.wrData[`MDNSU_SC_MSB:`MDNSU_SC_LSB];
            if (st_q.state == ST_W0123)
            begin
                st_d.op = OP_SHIFT;
                st_d.shfStart = 1'b1;
                st_d.state = ST_SHF;
                st_d.ctrl.ovFlag =
                    isNorm(sfrAccess.wrData[`MDNSU_SC_MSB:`MDNSU_SC_LSB]) &&
                    st_q.bytes[3][7];
            end
        end

        if (divDone && st_q.state == ST_DIV)
        begin
            st_d.bytes[1:0] = divQuot[15:0];
            if (st_q.op == OP_DIV32)
                st_d.bytes[3:2] = divQuot[31:16];
            st_d.bytes[5:4] = divRem;
            st_d.readPos = 3'h0;
            st_d.state = ST_READ;
        end

        // shift or normalization result
        if (shfDone && st_q.state == ST_SHF)
        begin
            st_d.bytes[3:0] = shfResult;
            if (isNorm(st_q.ctrl.shiftCount))
                st_d.ctrl.shiftCount = shfCount;
            st_d.readPos = 3'h0;
            st_d.state = ST_READ;
        end

        if (errSet)
            st_d.ctrl.errFlag = 1'b1;
        else if (errClr)
            st_d.ctrl.errFlag = 1'b0;

        st_d.busy = (st_d.state == ST_DIV) || (st_d.state == ST_SHF);
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign sfrReadData = st_q.rdData;
    assign controlStatus = ctrlByte(st_q.ctrl);
    assign busy = st_q.busy;
endmodule

// File: hdl/mdnsu_defines.svh
// constants of the multiply, divide, normalize and shift unit
`ifndef MDNSU_DEFINES_SVH
`define MDNSU_DEFINES_SVH

// access select codes: 3'h0..3'h5 pick an operand byte
`define MDNSU_SEL_BYTE_LAST 3'h5
`define MDNSU_SEL_CTRL 3'h6

// control/status field positions
`define MDNSU_ERR_BIT 7
`define MDNSU_OVF_BIT 6
`define MDNSU_DIR_BIT 5
`define MDNSU_SC_MSB 4
`define MDNSU_SC_LSB 0

// reset values
`define MDNSU_BYTE_RESET 8'h00
`define MDNSU_CTRL_RESET 8'h00
`define MDNSU_UNMAPPED_READ 8'h00

// timing and limits
`define MDNSU_DIV_LAST_STEP 5'h1f
`define MDNSU_SC_NORM 5'h00
`define MDNSU_SC_MAX 5'h1f
`define MDNSU_MUL_LIMIT 32'h0000ffff

`endif

// File: hdl/mdnsu_pkg.sv
// types of the multiply, divide, normalize and shift unit
package mdnsu_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_W0 = 4'h1,
        ST_W01 = 4'h2,
        ST_W012 = 4'h3,
        ST_W0123 = 4'h4,
        ST_W01234 = 4'h5,
        ST_W014 = 4'h6,
        ST_W04 = 4'h7,
        ST_W041 = 4'h8,
        ST_DIV = 4'h9,
        ST_SHF = 4'ha,
        ST_READ = 4'hb
    } mdnsu_state_type;

    typedef enum logic [1:0] {
        OP_DIV32 = 2'h0,
        OP_DIV16 = 2'h1,
        OP_MUL = 2'h2,
        OP_SHIFT = 2'h3
    } mdnsu_op_type;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [2:0] sel;
        logic [7:0] wrData;
    } mdnsu_access_type;

    typedef struct packed {
        logic errFlag;
        logic ovFlag;
        logic dirRight;
        logic [4:0] shiftCount;
    } mdnsu_ctrl_type;

    typedef struct packed {
        mdnsu_state_type state;
        mdnsu_op_type op;
        logic [2:0] readPos;
        logic [5:0][7:0] bytes;
        mdnsu_ctrl_type ctrl;
        logic [7:0] rdData;
        logic divStart;
        logic shfStart;
        logic busy;
    } mdnsu_top_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] step;
        logic [31:0] quot;
        logic [15:0] rem;
        logic [15:0] divisor;
    } mdnsu_div_type;

    typedef struct packed {
        logic busy;
        logic done;
        logic norm;
        logic right;
        logic [4:0] left;
        logic [4:0] count;
        logic [31:0] value;
    } mdnsu_shf_type;

endpackage

// File: hdl/mdnsu_divider.sv
// iterative 32-by-16 restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`include "mdnsu_defines.svh"

module mdnsu_divider (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // request
    input wire logic start,
    input wire logic [31:0] dividend,
    input wire logic [15:0] divisor,
    // result
    output logic done,
    output logic [31:0] quotient,
    output logic [15:0] remainder
);
    import mdnsu_pkg::*;

    mdnsu_div_type st_q;
    mdnsu_div_type st_d;
    logic [17:0] trial;

    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        trial = {1'b0, st_q.rem, st_q.quot[31]} - {2'b00, st_q.divisor};
        if (start)
        begin
            st_d.busy = 1'b1;
            st_d.step = 5'h00;
            st_d.quot = dividend;
            st_d.rem = 16'h0000;
            st_d.divisor = divisor;
        end
        else if (st_q.busy)
        begin
            // a borrow means the partial remainder stays as shifted
            if (trial[17])
                st_d.rem = {st_q.rem[14:0], st_q.quot[31]};
            else
                st_d.rem = trial[15:0];
            st_d.quot = {st_q.quot[30:0], ~trial[17]};
            st_d.step = st_q.step + 5'h01;
            if (st_q.step == `MDNSU_DIV_LAST_STEP)
            begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign done = st_q.done;
    assign quotient = st_q.quot;
    assign remainder = st_q.rem;
endmodule

// File: hdl/mdnsu_shifter.sv
// iterative 32-bit shifter and normalizer, one position per clock
`timescale 1ns/1ps
`include "mdnsu_defines.svh"

module mdnsu_shifter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // request
    input wire logic start,
    input wire logic norm,
    input wire logic right,
    input wire logic [4:0] count,
    input wire logic [31:0] operand,
    // result
    output logic done,
    output logic [31:0] result,
    output logic [4:0] shifts
);
    import mdnsu_pkg::*;

    mdnsu_shf_type st_q;
    mdnsu_shf_type st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.done = 1'b0;
        if (start)
        begin
            st_d.busy = 1'b1;
            st_d.norm = norm;
            st_d.right = right;
            st_d.left = count;
            st_d.count = 5'h00;
            st_d.value = operand;
        end
        else if (st_q.busy)
        begin
            if (st_q.norm)
            begin
                // a zero operand stops at the widest count field value
                if (st_q.value[31] || st_q.count == `MDNSU_SC_MAX)
                begin
                    st_d.busy = 1'b0;
                    st_d.done = 1'b1;
                end
                else
                begin
                    st_d.value = {st_q.value[30:0], 1'b0};
                    st_d.count = st_q.count + 5'h01;
                end
            end
            else if (st_q.left == 5'h00)
            begin
                st_d.busy = 1'b0;
                st_d.done = 1'b1;
            end
            else
            begin
                if (st_q.right)
                    st_d.value = {1'b0, st_q.value[31:1]};
                else
                    st_d.value = {st_q.value[30:0], 1'b0};
                st_d.left = st_q.left - 5'h01;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign done = st_q.done;
    assign result = st_q.value;
    assign shifts = st_q.count;
endmodule

// File: bench/mdnsu_unit_checker.sv
// port property checker for the arithmetic unit
`timescale 1ns/1ps
`include "mdnsu_defines.svh"

module mdnsu_unit_checker (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // access and results
    input wire mdnsu_pkg::mdnsu_access_type sfrAccess,
    input wire logic [7:0] sfrReadData,
    input wire logic [7:0] controlStatus,
    input wire logic busy
);
    import mdnsu_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    logic rd;
    logic wr;
    logic [2:0] sel;
    logic ctl;
    assign rd = sfrAccess.rdEn;
    assign wr = sfrAccess.wrEn;
    assign sel = sfrAccess.sel;
    assign ctl = (sfrAccess.sel == `MDNSU_SEL_CTRL);

    a_unmapped_zero:
        assert property (rd && sel == 3'h7 ##1 !rd |=> sfrReadData == 8'h00)
        else $error("unmapped read not zero");
    a_read_data_holds:
        assert property (!rd && !$past(rd) |=> $stable(sfrReadData))
        else $error("read data moved without a read");
    a_status_read_clears:
        assert property (rd && ctl && !wr |=> !controlStatus[7])
        else $error("status read left error flag set");
    a_restart_sets_error:
        assert property (wr && sel == 3'h0 && busy |=> controlStatus[7])
        else $error("restart during compute not flagged");
    a_busy_has_cause:
        assert property ($rose(busy) |-> $past(wr) &&
            ($past(sel) == 3'h5 || $past(sel) == `MDNSU_SEL_CTRL))
        else $error("busy rose without a starting write");
    a_busy_bounded:
        assert property ($rose(busy) |-> ##[1:40] !busy)
        else $error("operation did not finish in time");
    a_dir_bit_stored:
        assert property (wr && ctl && !busy |=>
            controlStatus[5] == $past(sfrAccess.wrData[5]))
        else $error("direction bit not stored");
    a_count_stored:
        assert property (wr && ctl && !busy && sfrAccess.wrData[4:0] != 5'h00
            |=> controlStatus[4:0] == $past(sfrAccess.wrData[4:0]))
        else $error("shift count not stored");
    a_flag_not_writable:
        assert property (wr && ctl && !controlStatus[7] |=> !controlStatus[7])
        else $error("control write set error flag");

    c_compute: cover property ($rose(busy));
    c_error_read: cover property (rd && ctl && controlStatus[7]);
    c_finish: cover property ($fell(busy));
endmodule

// File: bench/mdnsu_cpu_model.sv
// processor side register access driver for the arithmetic unit
`timescale 1ns/1ps

module mdnsu_cpu_model (
    // clock
    input wire logic ref_clk,
    // register access
    output mdnsu_pkg::mdnsu_access_type acc,
    input wire logic [7:0] rdData
);
    import mdnsu_pkg::*;
    initial acc = '0;

    // one access, entered just after an edge, leaves an idle cycle behind
    task automatic xfer(input logic w, input logic [2:0] s,
        input logic [7:0] d, output logic [7:0] q);
        acc.wrEn = w;
        acc.rdEn = !w;
        acc.sel = s;
        acc.wrData = d;
        @(posedge ref_clk);
        #1 acc = '0;
        @(posedge ref_clk);
        #1 q = rdData;
    endtask
endmodule

// File: bench/test_mul_div_norm_shift_unit.sv
// self-checking bench for the arithmetic unit
`timescale 1ns/1ps

module test_mul_div_norm_shift_unit;
    import mdnsu_pkg::*;
    logic refClk;
    logic resetN;
    mdnsu_access_type acc;
    logic [7:0] rdData;
    logic [7:0] ctrlStat;
    logic busyOut;
    logic [7:0] q8;
    int failures;
    int nCompared;

    mdnsu_unit dut_u (
        .ref_clk(refClk),
        .reset_n(resetN),
        .sfrAccess(acc),
        .sfrReadData(rdData),
        .controlStatus(ctrlStat),
        .busy(busyOut)
    );

    mdnsu_cpu_model cpu_u (
        .ref_clk(refClk),
        .acc(acc),
        .rdData(rdData)
    );

    always #5 refClk = ~refClk;

    task automatic summarize;
        if (failures == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        nCompared++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [2:0] s, input logic [7:0] d);
        logic [7:0] q;
        cpu_u.xfer(1'b1, s, d, q);
    endtask

    task automatic rd(input logic [2:0] s, output logic [7:0] q);
        cpu_u.xfer(1'b0, s, 8'h00, q);
    endtask

    task automatic waitIdle;
        repeat (50)
            if (busyOut !== 1'b0)
                @(posedge refClk) #1;
        cmp("busy", 0, busyOut);
    endtask

    task automatic load4(input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            wr(3'(i), v[8*i +: 8]);
    endtask

    task automatic read4(output logic [31:0] v);
        for (int i = 0; i < 4; i++)
            rd(3'(i), v[8*i +: 8]);
    endtask

    task automatic mul(input logic [15:0] a, input logic [15:0] b);
        logic [31:0] p;
        wr(3'h0, a[7:0]);
        wr(3'h4, b[7:0]);
        wr(3'h1, a[15:8]);
        wr(3'h5, b[15:8]);
        read4(p);
        cmp("product", a * b, p);
        cmp("mul overflow", a * b > 32'h0000ffff, ctrlStat[6]);
        cmp("mul error", 0, ctrlStat[7]);
    endtask

    task automatic div(input logic [31:0] a, input logic [15:0] b,
        input logic half);
        logic [31:0] q;
        logic [31:0] e;
        logic [15:0] r;
        q = '0;
        e = half ? {16'h0000, a[15:0]} : a;
        wr(3'h0, a[7:0]);
        wr(3'h1, a[15:8]);
        if (!half)
        begin
            wr(3'h2, a[23:16]);
            wr(3'h3, a[31:24]);
        end
        wr(3'h4, b[7:0]);
        wr(3'h5, b[15:8]);
        cmp("div busy", 1, busyOut);
        waitIdle();
        rd(3'h0, q[7:0]);
        rd(3'h1, q[15:8]);
        if (!half)
        begin
            rd(3'h2, q[23:16]);
            rd(3'h3, q[31:24]);
        end
        rd(3'h4, r[7:0]);
        rd(3'h5, r[15:8]);
        if (b != 16'h0000)
        begin
            cmp("quotient", e / b, q);
            cmp("remainder", e % b, r);
        end
        cmp("div overflow", b == 16'h0000, ctrlStat[6]);
        cmp("div error", 0, ctrlStat[7]);
    endtask

    task automatic shf(input logic [31:0] v, input logic [7:0] c);
        logic [31:0] r;
        logic [31:0] e;
        int z;
        z = 0;
        e = v;
        load4(v);
        wr(3'h6, c);
        cmp("shift busy", 1, busyOut);
        waitIdle();
        read4(r);
        if (c[4:0] == 5'h00)
        begin
            while (z < 31 && e[31] == 1'b0)
            begin
                e = e << 1;
                z++;
            end
            cmp("norm count", z, ctrlStat[4:0]);
            cmp("norm overflow", v[31], ctrlStat[6]);
        end
        else
        begin
            e = c[5] ? v >> c[4:0] : v << c[4:0];
            cmp("shift count", c[4:0], ctrlStat[4:0]);
        end
        cmp("direction", c[5], ctrlStat[5]);
        cmp("shift value", e, r);
        cmp("shift error", 0, ctrlStat[7]);
    endtask

    initial
    begin
        failures = 0;
        nCompared = 0;
        refClk = 1'b0;
        resetN = 1'b0;
        repeat (3) @(posedge refClk);
        #1 resetN = 1'b1;
        cmp("status reset", 8'h00, ctrlStat);
        rd(3'h7, q8);
        cmp("unmapped read", 8'h00, q8);
        rd(3'h0, q8);
        cmp("byte reset", 8'h00, q8);
        mul(16'h0003, 16'h0005);
        mul(16'h1234, 16'h5678);
        mul(16'hffff, 16'hffff);
        div(32'h12345678, 16'h1234, 1'b0);
        div(32'h0000fedc, 16'h0007, 1'b1);
        div(32'h00001000, 16'h0000, 1'b0);
        div(32'hffffffff, 16'hffff, 1'b0);
        shf(32'h00012345, 8'h00);
        shf(32'h80000001, 8'h00);
        shf(32'h00000000, 8'h00);
        shf(32'hf0000001, 8'h24);
        shf(32'h00000f0f, 8'h03);
        shf(32'h80000000, 8'h3f);
        shf(32'h00000001, 8'h1f);
        wr(3'h0, 8'h11);
        wr(3'h4, 8'h22);
        wr(3'h0, 8'h33);
        cmp("restart error", 1, ctrlStat[7]);
        rd(3'h6, q8);
        cmp("error read", 1, q8[7]);
        cmp("error cleared", 0, ctrlStat[7]);
        wr(3'h2, 8'h44);
        cmp("order error", 1, ctrlStat[7]);
        mul(16'h00ff, 16'h0101);
        load4(32'h00010000);
        wr(3'h4, 8'h03);
        wr(3'h5, 8'h00);
        wr(3'h0, 8'h55);
        cmp("busy error", 1, ctrlStat[7]);
        waitIdle();
        rd(3'h6, q8);
        cmp("error cleared", 0, ctrlStat[7]);
        summarize();
    end

    initial
    begin
        #100000;
        failures++;
        summarize();
    end
endmodule

bind mdnsu_unit mdnsu_unit_checker chk_u (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sfrAccess(sfrAccess),
    .sfrReadData(sfrReadData),
    .controlStatus(controlStatus),
    .busy(busy)
);
